// File: design/ptq_pkg.sv
package ptq_pkg;

   localparam int CNT_W = 16;
   localparam int NUM_CH = 4;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_LIMA = 8'h04;
   localparam logic [7:0] OFS_LIMB = 8'h08;
   localparam logic [7:0] OFS_STAT = 8'h0C;

   // control register fields
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_CLASS_LSB = 1;
   localparam int CTRL_SRC_LSB = 4;
   localparam int CTRL_POL_LSB = 6;
   localparam int CTRL_REJECT_BIT = 8;
   localparam int CTRL_OUTSIDE_BIT = 9;
   localparam int CTRL_SLOWER_BIT = 10;
   localparam int CTRL_USED_W = 11;

   // status register fields
   localparam int STAT_CMP_LSB = 0;
   localparam int STAT_TRK_LSB = 4;
   localparam int STAT_CNT_LSB = 16;

   // reset values
   localparam logic [CTRL_USED_W-1:0] CTRL_RST = 11'h000;
   localparam logic [CNT_W-1:0] LIMA_RST = 16'h0010;
   localparam logic [CNT_W-1:0] LIMB_RST = 16'h0040;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;

   typedef enum logic [2:0] {
      CLS_GLITCH,
      CLS_RUNT,
      CLS_WIDTH,
      CLS_SLEW,
      CLS_TIMEOUT
   } ptq_class_e;

   typedef enum logic [1:0] {
      POL_POS,
      POL_NEG,
      POL_EITHER
   } ptq_pol_e;

   typedef enum logic [1:0] {
      TRK_IDLE,
      TRK_UP,
      TRK_DN
   } ptq_trk_e;

   // comparator outputs of one channel: above upper, above level, above lower
   typedef struct packed {
      logic upper;
      logic level;
      logic lower;
   } ptq_cmp_s;

   typedef struct packed {
      logic slower;
      logic outside;
      logic reject;
      logic [1:0] pol;
      logic [1:0] src;
      logic [2:0] cls;
      logic en;
   } ptq_ctrl_s;

endpackage : ptq_pkg

// File: design/ptq_qualifier.sv
// Contract
// - five pulse classes; only the selected class may raise a trigger
// - one of four channels is the source for every class
// - glitch positive triggers on positive pulse narrower than glitch width
// - glitch negative triggers on negative pulse narrower than glitch width
// - glitch either triggers on any pulse narrower than glitch width
// - accept triggers on narrower pulses, reject triggers on wider pulses
// - runt positive: rise through lower, fall back, never cross upper
// - runt negative: fall through upper, rise back, never cross lower
// - runt either: cross one threshold, recross it before the other
// - runt trigger fires when the first threshold is recrossed
// - width triggers when pulse width is inside, or optionally outside, limits
// - width positive and negative polarity are separately selectable
// - slew positive qualifies edge crossing lower then upper threshold
// - slew negative qualifies edge crossing upper then lower threshold
// - slew either qualifies edge crossing either threshold then the other
// - slew triggers when transit is faster, or slower, than the set rate
// - timeout high triggers when level stays high longer than timeout
// - timeout low triggers when level stays low longer than timeout
// - timeout either triggers when level stays on either side for timeout
//
// The register offsets and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none

module ptq_qualifier
   import ptq_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire ptq_cmp_s input_channel_one,
   input wire ptq_cmp_s input_channel_two,
   input wire ptq_cmp_s input_channel_three,
   input wire ptq_cmp_s input_channel_four,
   output logic trig_out
);

   function automatic logic pol_ok(input logic [1:0] pol, input logic positive);
      pol_ok = (pol == POL_EITHER) || (positive ? (pol == POL_POS) : (pol == POL_NEG));
   endfunction : pol_ok

   ptq_ctrl_s ctrl_q;
   logic [CNT_W-1:0] lima_q;
   logic [CNT_W-1:0] limb_q;
   logic [CNT_W-1:0] tcnt_q;
   logic wr_pend_q;
   logic [7:0] wr_addr_q;
   logic [31:0] hrdata_q;
   logic addr_ph;

   ptq_cmp_s ch_in [NUM_CH];
   ptq_cmp_s s1_q [NUM_CH];
   ptq_cmp_s s2_q [NUM_CH];
   ptq_cmp_s cur;
   ptq_cmp_s prev_q;
   logic lvl_rise, lvl_fall, lvl_edge;
   logic lo_rise, lo_fall, hi_rise, hi_fall;

   logic [CNT_W-1:0] run_q;
   logic run_vld_q;
   ptq_trk_e trk_q;
   logic [CNT_W-1:0] tr_q;
   logic up_done, up_back, dn_done, dn_back;

   logic hit_glitch, hit_runt, hit_width, hit_slew, hit_timeout;
   logic hit_sel;
   logic trig_q;

   // ---------------- register bus ----------------
   // zero wait states: every transfer completes in its first data-phase cycle
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign addr_ph = hsel && htrans[1] && hready;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else begin
         wr_pend_q <= addr_ph && hwrite;
         wr_addr_q <= haddr[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= ptq_ctrl_s'(CTRL_RST);
         lima_q <= LIMA_RST;
         limb_q <= LIMB_RST;
      end else if (wr_pend_q) begin
         case (wr_addr_q)
            OFS_CTRL: ctrl_q <= ptq_ctrl_s'(hwdata[CTRL_USED_W-1:0]);
            OFS_LIMA: lima_q <= hwdata[CNT_W-1:0];
            OFS_LIMB: limb_q <= hwdata[CNT_W-1:0];
            default: ;
         endcase
      end
   end

   // read data is sampled in the address phase; a read right behind a write
   // to the same register returns the value before that write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h0000_0000;
      end else if (addr_ph && !hwrite) begin
         case (haddr[7:0])
            OFS_CTRL: hrdata_q <= {21'h00_0000, ctrl_q};
            OFS_LIMA: hrdata_q <= {16'h0000, lima_q};
            OFS_LIMB: hrdata_q <= {16'h0000, limb_q};
            OFS_STAT: hrdata_q <= {tcnt_q, 10'h000, trk_q, 1'b0, prev_q};
            default: hrdata_q <= 32'h0000_0000;
         endcase
      end
   end
   assign hrdata = hrdata_q;

   // trigger counter; a write to status clears it, a trigger in that cycle is counted after the clear, leaving one
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tcnt_q <= '0;
      end else if (trig_q) begin
         tcnt_q <= (wr_pend_q && wr_addr_q == OFS_STAT) ? CNT_ONE : tcnt_q + CNT_ONE;
      end else if (wr_pend_q && wr_addr_q == OFS_STAT) begin
         tcnt_q <= '0;
      end
   end

   // ---------------- comparator synchronisers ----------------
   assign ch_in[0] = input_channel_one;
   assign ch_in[1] = input_channel_two;
   assign ch_in[2] = input_channel_three;
   assign ch_in[3] = input_channel_four;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi++) begin : g_sync
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               s1_q[gi] <= '0;
               s2_q[gi] <= '0;
            end else begin
               s1_q[gi] <= ch_in[gi];
               s2_q[gi] <= s1_q[gi];
            end
         end
      end
   endgenerate

   assign cur = s2_q[ctrl_q.src];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prev_q <= '0;
      end else begin
         prev_q <= cur;
      end
   end

   assign lvl_rise = cur.level && !prev_q.level;
   assign lvl_fall = !cur.level && prev_q.level;
   assign lvl_edge = lvl_rise || lvl_fall;
   assign lo_rise = cur.lower && !prev_q.lower;
   assign lo_fall = !cur.lower && prev_q.lower;
   assign hi_rise = cur.upper && !prev_q.upper;
   assign hi_fall = !cur.upper && prev_q.upper;

   // ---------------- level run length ----------------
   // run_q is the number of cycles the level has held; on an edge it is the
   // width of the pulse that just ended
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         run_q <= '0;
         run_vld_q <= 1'b0;
      end else if (lvl_edge) begin
         run_q <= CNT_ONE;
         run_vld_q <= 1'b1;
      end else if (run_q != CNT_MAX) begin
         run_q <= run_q + CNT_ONE;
      end
   end

   // ---------------- threshold crossing tracker ----------------
   // shared by runt and slew: UP after rising through lower only,
   // DN after falling through upper only
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trk_q <= TRK_IDLE;
         tr_q <= '0;
      end else begin
         if (tr_q != CNT_MAX) begin
            tr_q <= tr_q + CNT_ONE;
         end
         if (hi_fall && cur.lower && !lo_fall) begin
            trk_q <= TRK_DN;
            tr_q <= CNT_ONE;
         end else if (lo_rise && !cur.upper && !hi_rise) begin
            trk_q <= TRK_UP;
            tr_q <= CNT_ONE;
         end else begin
            case (trk_q)
               TRK_UP: if (hi_rise || lo_fall) trk_q <= TRK_IDLE;
               TRK_DN: if (hi_rise || lo_fall) trk_q <= TRK_IDLE;
               TRK_IDLE: trk_q <= TRK_IDLE;
               default: trk_q <= TRK_IDLE;
            endcase
         end
      end
   end

   assign up_done = (trk_q == TRK_UP) && hi_rise;
   assign up_back = (trk_q == TRK_UP) && lo_fall && !hi_rise;
   assign dn_done = (trk_q == TRK_DN) && lo_fall;
   assign dn_back = (trk_q == TRK_DN) && hi_rise && !lo_fall;

   // ---------------- class qualifiers ----------------
   always_comb begin
      hit_glitch = run_vld_q && ((lvl_fall && pol_ok(ctrl_q.pol, 1'b1)) ||
                                 (lvl_rise && pol_ok(ctrl_q.pol, 1'b0))) &&
                   (ctrl_q.reject ? (run_q > lima_q) : (run_q < lima_q));
      hit_runt = (up_back && pol_ok(ctrl_q.pol, 1'b1)) ||
                 (dn_back && pol_ok(ctrl_q.pol, 1'b0));
      hit_width = run_vld_q && ((lvl_fall && pol_ok(ctrl_q.pol, 1'b1)) ||
                                (lvl_rise && pol_ok(ctrl_q.pol, 1'b0))) &&
                  (((run_q >= lima_q) && (run_q <= limb_q)) ^ ctrl_q.outside);
      hit_slew = ((up_done && pol_ok(ctrl_q.pol, 1'b1)) ||
                  (dn_done && pol_ok(ctrl_q.pol, 1'b0))) &&
                 (ctrl_q.slower ? (tr_q > lima_q) : (tr_q < lima_q));
      // fires once, in the cycle the level has held exactly the limit (run_q == lima_q)
      hit_timeout = !lvl_edge && (run_q == lima_q) && (run_q != CNT_MAX) &&
                    pol_ok(ctrl_q.pol, cur.level);
      case (ctrl_q.cls)
         CLS_GLITCH: hit_sel = hit_glitch;
         CLS_RUNT: hit_sel = hit_runt;
         CLS_WIDTH: hit_sel = hit_width;
         CLS_SLEW: hit_sel = hit_slew;
         CLS_TIMEOUT: hit_sel = hit_timeout;
         default: hit_sel = 1'b0;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trig_q <= 1'b0;
      end else begin
         trig_q <= ctrl_q.en && hit_sel;
      end
   end
   assign trig_out = trig_q;

   // ---------------- assertions ----------------
   default clocking dcb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_enter_up;
      lo_rise && !cur.upper && !hi_rise && !hi_fall;
   endsequence

   sequence s_runt_pos_back;
      (trk_q == TRK_UP) && lo_fall && !hi_rise;
   endsequence

   a_trig_single_cycle: assert property (trig_q |=> !trig_q)
      else $error("trigger held longer than one cycle");

   a_timeout_no_edge: assert property ((ctrl_q.cls == CLS_TIMEOUT) && lvl_edge |=> !trig_q)
      else $error("timeout class fired on a level edge");

   a_glitch_pos_hit: assert property (ctrl_q.en && ctrl_q.cls == CLS_GLITCH &&
      ctrl_q.pol == POL_POS && !ctrl_q.reject && run_vld_q && lvl_fall &&
      run_q < lima_q |=> trig_out)
      else $error("narrow positive glitch missed");

   a_glitch_neg_hit: assert property (ctrl_q.en && ctrl_q.cls == CLS_GLITCH &&
      ctrl_q.pol == POL_NEG && !ctrl_q.reject && run_vld_q && lvl_rise &&
      run_q < lima_q |=> trig_out)
      else $error("narrow negative glitch missed");

   a_glitch_reject_gate: assert property (ctrl_q.cls == CLS_GLITCH && ctrl_q.reject &&
      run_q <= lima_q |=> !trig_out)
      else $error("reject mode fired on a narrow pulse");

   a_runt_enter_up: assert property (s_enter_up |=> trk_q == TRK_UP)
      else $error("rise through lower threshold not tracked");

   a_runt_pos_hit: assert property (ctrl_q.en && ctrl_q.cls == CLS_RUNT &&
      (ctrl_q.pol == POL_POS || ctrl_q.pol == POL_EITHER) ##0
      s_runt_pos_back |=> trig_out)
      else $error("positive runt recross missed");

   a_runt_neg_hit: assert property (ctrl_q.en && ctrl_q.cls == CLS_RUNT &&
      ctrl_q.pol == POL_NEG && trk_q == TRK_DN && hi_rise && !lo_fall |=> trig_out)
      else $error("negative runt recross missed");

   a_width_inside_hit: assert property (ctrl_q.en && ctrl_q.cls == CLS_WIDTH &&
      ctrl_q.pol == POL_POS && !ctrl_q.outside && run_vld_q && lvl_fall &&
      run_q >= lima_q && run_q <= limb_q |=> trig_out)
      else $error("in-range positive width missed");

   a_slew_fast_hit: assert property (ctrl_q.en && ctrl_q.cls == CLS_SLEW &&
      (ctrl_q.pol == POL_POS || ctrl_q.pol == POL_EITHER) && !ctrl_q.slower &&
      trk_q == TRK_UP && hi_rise && tr_q < lima_q |=> trig_out)
      else $error("fast rising edge missed");

   a_slew_neg_hit: assert property (ctrl_q.en && ctrl_q.cls == CLS_SLEW &&
      ctrl_q.pol == POL_NEG && ctrl_q.slower && trk_q == TRK_DN && lo_fall &&
      tr_q > lima_q |=> trig_out)
      else $error("slow falling edge missed");

   a_timeout_high_hit: assert property (ctrl_q.en && ctrl_q.cls == CLS_TIMEOUT &&
      (ctrl_q.pol == POL_POS || ctrl_q.pol == POL_EITHER) && cur.level && !lvl_edge &&
      run_q == lima_q && lima_q != CNT_MAX |=> trig_out)
      else $error("high timeout missed");

   a_timeout_low_hit: assert property (ctrl_q.en && ctrl_q.cls == CLS_TIMEOUT &&
      ctrl_q.pol == POL_NEG && !cur.level && !lvl_edge && run_q == lima_q &&
      lima_q != CNT_MAX |=> trig_out)
      else $error("low timeout missed");

   a_run_count_step: assert property (!lvl_edge && run_q != CNT_MAX |=>
      run_q == $past(run_q) + CNT_ONE)
      else $error("run length did not advance");

   a_width_neg_hit: assert property (ctrl_q.en && ctrl_q.cls == CLS_WIDTH &&
      ctrl_q.pol == POL_NEG && !ctrl_q.outside && run_vld_q && lvl_rise &&
      run_q >= lima_q && run_q <= limb_q |=> trig_out)
      else $error("in-range negative width missed");

   // disabled block, unused class codes and the unused polarity code must stay silent
   a_unused_code_quiet: assert property (!ctrl_q.en || ctrl_q.cls > CLS_TIMEOUT ||
      ctrl_q.pol > POL_EITHER |=> !trig_out)
      else $error("trigger raised while disabled or on an unused code");

endmodule : ptq_qualifier

`default_nettype wire

// File: verification/ptq_cmp_model.sv
`timescale 1ns/10ps
`default_nettype none
// comparator bank: the chosen channel follows lvl (0 below all thresholds, 3 above all);
// the others show the mirrored level, so a misrouted source sees the wrong edges
module ptq_cmp_model
   import ptq_pkg::*;
(
   input wire logic [1:0] lvl,
   input wire logic [1:0] chan,
   output var ptq_cmp_s ch_one,
   output var ptq_cmp_s ch_two,
   output var ptq_cmp_s ch_three,
   output var ptq_cmp_s ch_four
);
   // thresholds are ordered lower < level < upper, so outputs are always a thermometer code
   function automatic ptq_cmp_s thermo(input logic [1:0] v);
      return ptq_cmp_s'({v == 2'h3, v >= 2'h2, v != 2'h0});
   endfunction : thermo

   always_comb begin
      ch_one = thermo(~lvl);
      ch_two = thermo(~lvl);
      ch_three = thermo(~lvl);
      ch_four = thermo(~lvl);
      case (chan)
         2'h0: ch_one = thermo(lvl);
         2'h1: ch_two = thermo(lvl);
         2'h2: ch_three = thermo(lvl);
         default: ch_four = thermo(lvl);
      endcase
   end
endmodule : ptq_cmp_model
`default_nettype wire

// File: verification/tb_ptq_qualifier.sv
`timescale 1ns/10ps
`default_nettype none
module tb_ptq_qualifier
   import ptq_pkg::*;
;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h00000000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h00000000;
   logic [1:0] lvl = 2'h0;
   logic [1:0] chan = 2'h0;
   logic [1:0] src_sel = 2'h0;
   logic prev_trig = 1'b0;
   logic hreadyout, hresp, trig_out;
   logic [31:0] hrdata, rd;
   ptq_cmp_s c1, c2, c3, c4;
   int fails = 0;
   int tests_run = 0;
   int trig_cnt = 0;

   always #2 hclk = ~hclk;

   ptq_qualifier ptq_qualifier_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .input_channel_one(c1), .input_channel_two(c2), .input_channel_three(c3),
      .input_channel_four(c4), .trig_out(trig_out)
   );
   ptq_cmp_model ptq_cmp_model_inst (
      .lvl(lvl), .chan(chan), .ch_one(c1), .ch_two(c2), .ch_three(c3), .ch_four(c4)
   );

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : final_report

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   always @(posedge hclk) begin
      if (trig_out === 1'b1) begin
         trig_cnt <= trig_cnt + 1;
         if (prev_trig === 1'b1) chk(32'h1, 32'h0);
      end
      prev_trig <= trig_out;
   end

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h000000, a};
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 40);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 40);
      rd = hrdata;
      if (n >= 40) begin
         fails++;
         final_report();
      end
   endtask : bus

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h00000000);
      chk(rd, e);
   endtask : rdc

   // the long settle lets edges from the previous case and the config write be judged first
   task automatic run(input logic [2:0] c, input logic [1:0] p, input logic [3:0] f,
         input int a, input int b, input int w, input int z, input int e);
      int base;
      bus(1'b1, OFS_CTRL, {21'h000000, f[3:1], p, src_sel, c, ~f[0]});
      lvl <= 2'(a);
      repeat (70) @(posedge hclk);
      base = trig_cnt;
      lvl <= 2'(b);
      repeat (w) @(posedge hclk);
      if (c != CLS_TIMEOUT) chk(32'(trig_cnt - base), 32'h0);
      lvl <= 2'(z);
      repeat (14) @(posedge hclk);
      chk(32'(trig_cnt - base), 32'(e));
   endtask : run

   initial begin
      repeat (20000) @(posedge hclk);
      fails++;
      final_report();
   end

   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk({31'h0, trig_out}, 32'h0);
      rdc(OFS_CTRL, 32'h0);
      rdc(OFS_LIMA, 32'h10);
      rdc(OFS_LIMB, 32'h40);
      bus(1'b1, 8'h10, 32'hA5A5A5A5);
      rdc(8'h10, 32'h0);
      run(CLS_GLITCH, POL_POS, 4'h0, 0, 2, 15, 0, 1);
      run(CLS_GLITCH, POL_POS, 4'h0, 0, 2, 16, 0, 0);
      run(CLS_GLITCH, POL_POS, 4'h0, 2, 0, 8, 2, 0);
      run(CLS_GLITCH, POL_NEG, 4'h0, 2, 0, 8, 2, 1);
      run(CLS_GLITCH, POL_NEG, 4'h0, 0, 2, 8, 0, 0);
      run(CLS_GLITCH, POL_EITHER, 4'h0, 2, 0, 8, 2, 1);
      run(CLS_GLITCH, POL_EITHER, 4'h0, 0, 2, 8, 0, 1);
      run(CLS_GLITCH, POL_POS, 4'h2, 0, 2, 20, 0, 1);
      run(CLS_GLITCH, POL_POS, 4'h2, 0, 2, 8, 0, 0);
      run(CLS_GLITCH, POL_POS, 4'h1, 0, 2, 8, 0, 0);
      run(3'h5, POL_POS, 4'h0, 0, 2, 8, 0, 0);
      run(CLS_GLITCH, 2'h3, 4'h0, 0, 2, 8, 0, 0);
      run(CLS_WIDTH, POL_POS, 4'h0, 0, 2, 8, 0, 0);
      run(CLS_RUNT, POL_POS, 4'h0, 0, 1, 6, 0, 1);
      run(CLS_RUNT, POL_POS, 4'h0, 0, 1, 6, 3, 0);
      run(CLS_RUNT, POL_POS, 4'h0, 3, 2, 6, 3, 0);
      run(CLS_RUNT, POL_NEG, 4'h0, 3, 2, 6, 3, 1);
      run(CLS_RUNT, POL_NEG, 4'h0, 3, 2, 6, 0, 0);
      run(CLS_RUNT, POL_EITHER, 4'h0, 0, 1, 6, 0, 1);
      run(CLS_RUNT, POL_EITHER, 4'h0, 3, 2, 6, 3, 1);
      run(CLS_WIDTH, POL_POS, 4'h0, 0, 2, 16, 0, 1);
      run(CLS_WIDTH, POL_POS, 4'h0, 0, 2, 65, 0, 0);
      run(CLS_WIDTH, POL_POS, 4'h4, 0, 2, 65, 0, 1);
      run(CLS_WIDTH, POL_POS, 4'h4, 0, 2, 40, 0, 0);
      run(CLS_WIDTH, POL_NEG, 4'h0, 2, 0, 64, 2, 1);
      run(CLS_WIDTH, POL_POS, 4'h0, 2, 0, 40, 2, 0);
      run(CLS_SLEW, POL_POS, 4'h0, 0, 1, 15, 3, 1);
      run(CLS_SLEW, POL_POS, 4'h0, 0, 1, 16, 3, 0);
      run(CLS_SLEW, POL_POS, 4'h8, 0, 1, 17, 3, 1);
      run(CLS_SLEW, POL_POS, 4'h8, 0, 1, 8, 3, 0);
      run(CLS_SLEW, POL_POS, 4'h0, 3, 2, 8, 0, 0);
      run(CLS_SLEW, POL_NEG, 4'h0, 3, 2, 8, 0, 1);
      run(CLS_SLEW, POL_NEG, 4'h0, 0, 1, 8, 3, 0);
      run(CLS_SLEW, POL_EITHER, 4'h0, 3, 2, 8, 0, 1);
      run(CLS_SLEW, POL_EITHER, 4'h0, 0, 1, 8, 3, 1);
      run(CLS_TIMEOUT, POL_POS, 4'h0, 0, 3, 40, 0, 1);
      run(CLS_TIMEOUT, POL_POS, 4'h0, 0, 3, 14, 0, 0);
      run(CLS_TIMEOUT, POL_NEG, 4'h0, 3, 0, 20, 3, 1);
      run(CLS_TIMEOUT, POL_EITHER, 4'h0, 0, 3, 20, 0, 1);
      run(CLS_TIMEOUT, POL_EITHER, 4'h0, 3, 0, 20, 3, 1);
      src_sel = 2'h2;
      run(CLS_GLITCH, POL_POS, 4'h0, 0, 2, 8, 0, 0);
      chan <= 2'h2;
      run(CLS_GLITCH, POL_POS, 4'h0, 0, 2, 8, 0, 1);
      run(CLS_RUNT, POL_POS, 4'h0, 0, 1, 6, 0, 1);
      bus(1'b1, OFS_STAT, 32'h00000000);
      run(CLS_GLITCH, POL_POS, 4'h0, 0, 2, 8, 0, 1);
      bus(1'b0, OFS_STAT, 32'h00000000);
      // count of one, tracker idle and the selected comparators all low
      chk(rd, 32'h0001_0000);
      bus(1'b1, OFS_LIMA, 32'h00000020);
      rdc(OFS_LIMA, 32'h20);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      chk({31'h0, trig_out}, 32'h0);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdc(OFS_CTRL, 32'h0);
      rdc(OFS_LIMA, 32'h10);
      chk({30'h0, hreadyout, hresp}, 32'h2);
      final_report();
   end
endmodule : tb_ptq_qualifier
`default_nettype wire
